/* File: src/fes_bus_cycle.sv */
`timescale 1ns/1ps

module fes_bus_cycle #(
  parameter int ACC_CYC = fes_pkg::ACCESS_CYC,
  parameter int WE_CYC  = fes_pkg::WE_PULSE_CYC
) (
  input  wire logic                        clk_i,
  input  wire logic                        arst_n_i,
  input  wire logic                        start_i,
  input  wire logic                        write_i,
  input  wire logic [fes_pkg::ADDR_W-1:0]  addr_i,
  input  wire logic [fes_pkg::DATA_W-1:0]  wdata_i,
  input  wire logic [fes_pkg::DATA_W-1:0]  dq_i,
  output fes_pkg::fes_pins_s               pins_o,
  output logic                             done_o,
  output logic [fes_pkg::DATA_W-1:0]       rdata_o
);

  // -------------------------------------------------------------------------
  // One strobed read or write: setup, strobe, release
  // -------------------------------------------------------------------------
  typedef enum logic [1:0] {
    CY_IDLE,
    CY_SETUP,
    CY_STROBE,
    CY_HOLD
  } fes_cy_e;

  fes_cy_e             st_reg;
  fes_cy_e             st_next;
  logic [3:0]          cnt_reg;
  logic                wr_reg;
  wire  logic [3:0]    strobe_len;
  wire  logic          strobe_end;

  assign strobe_len = wr_reg ? 4'(WE_CYC) : 4'(ACC_CYC);
  assign strobe_end = (st_reg == CY_STROBE) && (cnt_reg == strobe_len - 4'h1);

  always_comb
  begin
    st_next = st_reg;
    case (st_reg)
      CY_IDLE:   if (start_i) st_next = CY_SETUP;
      CY_SETUP:  st_next = CY_STROBE;
      CY_STROBE: if (strobe_end) st_next = CY_HOLD;
      default:   st_next = CY_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st_reg  <= CY_IDLE;
      cnt_reg <= 4'h0;
      wr_reg  <= 1'b0;
      pins_o  <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, dq: '0, dq_oe: 1'b0};
      done_o  <= 1'b0;
      rdata_o <= '0;
    end
    else
    begin
      st_reg      <= st_next;
      cnt_reg     <= (st_reg == CY_STROBE && !strobe_end) ? cnt_reg + 4'h1 : 4'h0;
      done_o      <= (st_reg == CY_HOLD);
      pins_o.ce_n <= !(st_next == CY_SETUP || st_next == CY_STROBE);
      pins_o.oe_n <= !(st_next == CY_STROBE && !wr_reg && !(st_reg == CY_IDLE));
      pins_o.we_n <= !(st_next == CY_STROBE && wr_reg);
      if (st_reg == CY_IDLE && start_i)
      begin
        wr_reg       <= write_i;
        pins_o.addr  <= addr_i;
        pins_o.dq    <= wdata_i;
        pins_o.dq_oe <= write_i;
      end
      else if (st_reg == CY_HOLD)
        pins_o.dq_oe <= 1'b0;
      if (strobe_end && !wr_reg)
        rdata_o <= dq_i;
    end
  end

  // -------------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------------
  we_pulse_len_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [RULE3]
    $fell(pins_o.we_n) |-> (!pins_o.we_n) [*2] ##1 pins_o.we_n)
    else $error("write strobe width wrong");

  no_contention_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !pins_o.oe_n |-> (!pins_o.dq_oe && !pins_o.ce_n))
    else $error("output enable while host drives data");

endmodule // fes_bus_cycle

/* File: src/fes_host_ctrl.sv */
// Operation
// RULE1: Erase ends in read mode, error holds status.
// RULE2: Block erase sets selected cells to one.
// RULE3: Suspend is one write, only pauses erase.
// RULE4: Erase halts within 15 us after suspend.
// RULE5: Suspend while adding blocks acts at once.
// RULE6: Suspended: other blocks normal, erasing give status.
// RULE7: Reset after auto-select returns to suspended state.
// RULE8: Only resume restarts; suspend repeatable.
// RULE9: Reads during program or erase give status.
// RULE10: Polling bit inverts programmed bit until done.
// RULE11: Polling bit zero in erase, one suspended.
// RULE12: Toggle bit flips per read while busy.
// RULE13: Error bit on failure; reset before others.
// RULE14: Programming zero back to one fails.
// RULE15: Timer bit zero while blocks still addable.
// RULE16: Alt toggle flips on erasing-block reads.
// RULE17: Alt toggle keeps flipping on failed blocks.
// RULE18: Host ignores undefined status bits.
// RULE19: Ready/busy low while busy, high suspended.
// RULE20: Running erase ignores all but suspend, reset.
// RULE21: Blocks added within 50 us of last.
`timescale 1ns/1ps

module fes_host_ctrl #(
  parameter logic [7:0] SUSPEND_CODE = fes_pkg::CODE_SUSPEND,
  parameter logic [7:0] RESUME_CODE  = fes_pkg::CODE_RESUME,
  parameter logic [7:0] RESET_CODE   = fes_pkg::CODE_RESET
) (
  input  wire logic                        clk_i,
  input  wire logic                        arst_n_i,
  input  wire logic                        req_valid_i,
  input  fes_pkg::fes_req_s                req_i,
  output logic                             req_ready_o,
  output logic                             rsp_valid_o,
  output logic [fes_pkg::DATA_W-1:0]       rsp_data_o,
  output logic                             rsp_error_o,
  output logic                             rsp_refused_o,
  output logic                             suspended_o,
  output logic                             erase_started_o,
  output logic                             add_window_o,
  output logic                             suspend_late_o,
  output fes_pkg::fes_pins_s               pins_o,
  input  wire logic [fes_pkg::DATA_W-1:0]  dq_i,
  input  wire logic                        ready_busy_out_i
);

  // -------------------------------------------------------------------------
  // Declarations
  // -------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WRITE,
    ST_READ,
    ST_POLL_A,
    ST_POLL_B,
    ST_EVAL,
    ST_ERR_CHK
  } fes_st_e;

  fes_st_e                       st_reg;
  fes_pkg::fes_req_s             cur_reg;
  logic                          bus_pend_reg;
  logic                          bus_start_reg;
  logic [fes_pkg::DATA_W-1:0]    s1_reg;
  logic [fes_pkg::DATA_W-1:0]    s2_reg;
  logic                          err_pend_reg;
  logic                          erase_run_reg;
  logic                          sus_act_reg;
  logic [fes_pkg::TMR_W-1:0]     sus_cnt_reg;
  logic [fes_pkg::TMR_W-1:0]     add_cnt_reg;
  logic                          bus_done;
  logic [fes_pkg::DATA_W-1:0]    bus_rdata;
  wire  logic                    bus_write;
  wire  logic [7:0]              wr_code;
  wire  logic                    take;
  wire  logic                    refuse;
  wire  logic                    toggling;
  wire  logic                    failed;
  wire  logic                    stopped_sus;

  // -------------------------------------------------------------------------
  // Request decode and status interpretation
  // -------------------------------------------------------------------------
  function automatic logic flips(input logic [7:0] a, input logic [7:0] b);
    flips = a[fes_pkg::BIT_TOGGLE] ^ b[fes_pkg::BIT_TOGGLE];
  endfunction

  assign take      = (st_reg == ST_IDLE) && req_valid_i;
  assign refuse    = (err_pend_reg && req_i.op != fes_pkg::OP_RESET)                // [RULE13]
                   || (erase_run_reg && !sus_act_reg && req_i.op == fes_pkg::OP_WRITE) // [RULE20]
                   || (req_i.op == fes_pkg::OP_RESUME && !suspended_o)            // [RULE8]
                   || (req_i.op == fes_pkg::OP_SUSPEND && suspended_o);           // [RULE3]
  assign bus_write = (st_reg == ST_WRITE);
  assign wr_code   = (cur_reg.op == fes_pkg::OP_SUSPEND) ? SUSPEND_CODE           // [RULE3]
                   : (cur_reg.op == fes_pkg::OP_RESUME)  ? RESUME_CODE
                   : (cur_reg.op == fes_pkg::OP_RESET)   ? RESET_CODE
                   : cur_reg.data;
  // Only toggle, error, polling and timer bits are looked at
  assign toggling    = flips(s1_reg, s2_reg);                                     // [RULE18]
  assign failed      = s2_reg[fes_pkg::BIT_ERROR];                                // [RULE13]
  assign stopped_sus = sus_act_reg && ready_busy_out_i                            // [RULE19]
                     && s2_reg[fes_pkg::BIT_DATA_POLL];                           // [RULE11]

  fes_bus_cycle u_bus (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .start_i  (bus_start_reg),
    .write_i  (bus_write),
    .addr_i   (cur_reg.addr),
    .wdata_i  (wr_code),
    .dq_i     (dq_i),
    .pins_o   (pins_o),
    .done_o   (bus_done),
    .rdata_o  (bus_rdata)
  );

  // -------------------------------------------------------------------------
  // Sequencer
  // -------------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st_reg          <= ST_IDLE;
      cur_reg         <= '0;
      bus_pend_reg    <= 1'b0;
      bus_start_reg   <= 1'b0;
      s1_reg          <= '0;
      s2_reg          <= '0;
      err_pend_reg    <= 1'b0;
      erase_run_reg   <= 1'b0;
      sus_act_reg     <= 1'b0;
      req_ready_o     <= 1'b0;
      rsp_valid_o     <= 1'b0;
      rsp_data_o      <= '0;
      rsp_error_o     <= 1'b0;
      rsp_refused_o   <= 1'b0;
      suspended_o     <= 1'b0;
      erase_started_o <= 1'b0;
    end
    else
    begin
      rsp_valid_o   <= 1'b0;
      rsp_refused_o <= 1'b0;
      bus_start_reg <= 1'b0;
      req_ready_o   <= (st_reg == ST_IDLE) && !take;
      if (st_reg != ST_IDLE && st_reg != ST_EVAL && !bus_pend_reg)
      begin
        bus_pend_reg  <= 1'b1;
        bus_start_reg <= 1'b1;
      end
      if (bus_done)
        bus_pend_reg <= 1'b0;
      case (st_reg)
        ST_IDLE:
          if (take)
          begin
            cur_reg <= req_i;
            if (refuse)
            begin
              rsp_valid_o   <= 1'b1;
              rsp_refused_o <= 1'b1;
            end
            else if (req_i.op == fes_pkg::OP_READ)
              st_reg <= ST_READ;
            else if (req_i.op == fes_pkg::OP_POLL)
              st_reg <= ST_POLL_A;
            else
              st_reg <= ST_WRITE;
          end
        ST_WRITE:
          if (bus_done)
          begin
            rsp_error_o <= 1'b0;
            if (cur_reg.op == fes_pkg::OP_SUSPEND)
            begin
              sus_act_reg <= 1'b1;
              st_reg      <= ST_POLL_A;
            end
            else
            begin
              st_reg      <= ST_IDLE;
              rsp_valid_o <= 1'b1;
              rsp_data_o  <= wr_code;
              if (cur_reg.op == fes_pkg::OP_RESUME)
              begin
                suspended_o   <= 1'b0;                                            // [RULE8]
                sus_act_reg   <= 1'b0;
                erase_run_reg <= 1'b1;
              end
              // Reset keeps a suspended erase suspended
              if (cur_reg.op == fes_pkg::OP_RESET)
              begin
                err_pend_reg  <= 1'b0;                                            // [RULE7]
                erase_run_reg <= suspended_o;
              end
            end
          end
        ST_READ:
          if (bus_done)
          begin
            st_reg      <= ST_IDLE;
            rsp_valid_o <= 1'b1;
            rsp_data_o  <= bus_rdata;
            rsp_error_o <= 1'b0;
          end
        ST_POLL_A:
          if (bus_done)
          begin
            s2_reg <= bus_rdata;
            st_reg <= ST_POLL_B;
          end
        ST_POLL_B:
          if (bus_done)
          begin
            s1_reg <= s2_reg;
            s2_reg <= bus_rdata;
            st_reg <= ST_EVAL;
          end
        ST_EVAL:
          if (toggling && failed)
            st_reg <= ST_ERR_CHK;
          else if (toggling)
          begin
            erase_run_reg   <= 1'b1;
            erase_started_o <= s2_reg[fes_pkg::BIT_ERASE_TIMER];                  // [RULE15]
            st_reg          <= ST_POLL_B;                                         // [RULE12]
          end
          else
          begin
            suspended_o   <= stopped_sus;
            erase_run_reg <= stopped_sus;
            sus_act_reg   <= stopped_sus;
            rsp_valid_o   <= 1'b1;
            rsp_data_o    <= s2_reg;
            rsp_error_o   <= 1'b0;
            st_reg        <= ST_IDLE;
          end
        ST_ERR_CHK:
          if (bus_done)
          begin
            rsp_valid_o <= 1'b1;
            rsp_data_o  <= bus_rdata;
            st_reg      <= ST_IDLE;
            if (flips(s2_reg, bus_rdata))
            begin
              err_pend_reg  <= 1'b1;                                              // [RULE13]
              rsp_error_o   <= 1'b1;
              erase_run_reg <= 1'b0;
            end
            else
              rsp_error_o <= 1'b0;
          end
        default:
          st_reg <= ST_IDLE;
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // Suspend deadline and block-add window
  // -------------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sus_cnt_reg    <= '0;
      suspend_late_o <= 1'b0;
    end
    else if (!sus_act_reg || suspended_o)
      sus_cnt_reg <= '0;
    else if (sus_cnt_reg != fes_pkg::TMR_W'(fes_pkg::SUSPEND_CYC))
      sus_cnt_reg <= sus_cnt_reg + 1'b1;
    else
      suspend_late_o <= 1'b1;                                                     // [RULE4]
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      add_cnt_reg  <= '0;
      add_window_o <= 1'b0;
    end
    else if (st_reg == ST_WRITE && bus_done && cur_reg.op == fes_pkg::OP_WRITE)
    begin
      add_cnt_reg  <= fes_pkg::TMR_W'(fes_pkg::ADD_WINDOW_CYC);                   // [RULE21]
      add_window_o <= 1'b1;
    end
    else if (add_cnt_reg != '0)
    begin
      add_cnt_reg  <= add_cnt_reg - 1'b1;
      add_window_o <= (add_cnt_reg != fes_pkg::TMR_W'(1));
    end
    else
      add_window_o <= 1'b0;
  end

  // -------------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------------
  err_gate_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [RULE13]
    (take && err_pend_reg && req_i.op != fes_pkg::OP_RESET) |=> (rsp_valid_o && rsp_refused_o))
    else $error("command taken while error pending");

  erase_gate_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [RULE20]
    (take && erase_run_reg && !sus_act_reg && req_i.op == fes_pkg::OP_WRITE)
      |=> rsp_refused_o ##1 (st_reg == ST_IDLE))
    else $error("write issued into running erase");

  resume_clear_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [RULE8]
    (st_reg == ST_WRITE && bus_done && cur_reg.op == fes_pkg::OP_RESUME)
      |=> (!suspended_o && rsp_valid_o && rsp_data_o == RESUME_CODE))
    else $error("resume did not clear suspended");

  add_window_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [RULE21]
    (st_reg == ST_WRITE && bus_done && cur_reg.op == fes_pkg::OP_WRITE)
      |=> add_window_o [*8])
    else $error("block-add window not opened");

  sus_late_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [RULE4]
    (sus_act_reg && !suspended_o && sus_cnt_reg == fes_pkg::TMR_W'(fes_pkg::SUSPEND_CYC))
      |=> suspend_late_o)
    else $error("late suspend not flagged");

  suspend_one_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [RULE3]
    (st_reg == ST_WRITE && bus_done && cur_reg.op == fes_pkg::OP_SUSPEND)
      |=> (st_reg == ST_POLL_A) ##1 (st_reg == ST_POLL_A && pins_o.we_n))
    else $error("suspend not a single write");

  cv_suspend_c: cover property (@(posedge clk_i) disable iff (!arst_n_i) $rose(suspended_o));
  cv_error_c:   cover property (@(posedge clk_i) disable iff (!arst_n_i) rsp_valid_o && rsp_error_o);
  cv_refuse_c:  cover property (@(posedge clk_i) disable iff (!arst_n_i) rsp_refused_o);
  cv_window_c:  cover property (@(posedge clk_i) disable iff (!arst_n_i) $fell(add_window_o));

endmodule // fes_host_ctrl

/* File: src/fes_pkg.sv */
package fes_pkg;

  // -------------------------------------------------------------------------
  // Widths
  // -------------------------------------------------------------------------
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;

  // -------------------------------------------------------------------------
  // Status word bit positions
  // -------------------------------------------------------------------------
  localparam int BIT_DATA_POLL   = 7;
  localparam int BIT_TOGGLE      = 6;
  localparam int BIT_ERROR       = 5;
  localparam int BIT_ERASE_TIMER = 3;
  localparam int BIT_ALT_TOGGLE  = 2;

  // -------------------------------------------------------------------------
  // Timing, 40 MHz clock
  // -------------------------------------------------------------------------
  localparam int CLK_PERIOD_PS    = 25000;
  localparam int ACCESS_NS        = 45;
  localparam int WE_PULSE_NS      = 30;
  localparam int SUSPEND_US       = 15;
  localparam int ADD_WINDOW_US    = 50;
  localparam int ACCESS_CYC       = (ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WE_PULSE_CYC     = (WE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SUSPEND_CYC      = (SUSPEND_US * 1000000) / CLK_PERIOD_PS;
  localparam int ADD_WINDOW_CYC   = (ADD_WINDOW_US * 1000000) / CLK_PERIOD_PS;
  localparam int TMR_W            = 12;

  // -------------------------------------------------------------------------
  // Command data codes, plain defaults
  // -------------------------------------------------------------------------
  localparam logic [7:0] CODE_SUSPEND = 8'hb0;
  localparam logic [7:0] CODE_RESUME  = 8'h30;
  localparam logic [7:0] CODE_RESET   = 8'hf0;

  // -------------------------------------------------------------------------
  // Types
  // -------------------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_READ,
    OP_WRITE,
    OP_POLL,
    OP_SUSPEND,
    OP_RESUME,
    OP_RESET
  } fes_op_e;

  typedef struct packed {
    fes_op_e             op;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data;
  } fes_req_s;

  typedef struct packed {
    logic                ce_n;
    logic                oe_n;
    logic                we_n;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   dq;
    logic                dq_oe;
  } fes_pins_s;

endpackage

/* File: verif/fes_flash_model.sv */
`timescale 1ns/1ps

// ---------------------------------------------------------------
// Flash device model
// ---------------------------------------------------------------
module fes_flash_model #(
  parameter int         WAIT_CYC   = 300,
  parameter int         ERASE_CYC  = 600,
  parameter int         PROG_CYC   = 40,
  parameter int         SUSP_CYC   = 20,
  parameter logic [7:0] ERASE_CODE = 8'h50
) (
  input  wire logic          clk_i,
  input  wire logic          arst_n_i,
  input  fes_pkg::fes_pins_s pins_i,
  input  wire logic          fail_i,
  output logic [7:0]         dq_o,
  output logic               ready_busy_out_o
);
  typedef enum logic [2:0] {S_RD, S_PG, S_WT, S_ER, S_SP, S_SU, S_EE} fes_fm_e;
  fes_fm_e     st;
  logic [7:0]  mem [0:131071];
  logic [7:0]  sel, bad, rd_q, pd, wd;
  logic [16:0] pa;
  logic        we_q, oe_q, ce_q, tog, alt, perr;
  int          cnt, ecnt;
  wire  [2:0]  blk   = pins_i.addr[16:14];
  wire         rd_ev = !pins_i.ce_n && !pins_i.oe_n && oe_q;
  wire         wr_ev = pins_i.we_n && !we_q && !ce_q;
  // Released bus shows the inverse of the last value
  assign dq_o = (!pins_i.ce_n && !pins_i.oe_n) ? rd_q : ~rd_q;
  assign wd = pins_i.dq;
  assign ready_busy_out_o = (st == S_RD) || (st == S_SU);

  initial for (int i = 0; i < 131072; i++) mem[i] = 8'hff;

  function automatic logic [7:0] stat();
    stat = 8'h00;
    stat[7] = (st == S_PG || (st == S_EE && perr)) ? ~pd[7] : (st == S_SU);
    stat[6] = tog;
    stat[5] = (st == S_EE);
    stat[3] = (st != S_WT);
    stat[2] = alt;
  endfunction

  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st <= S_RD;
      {sel, bad, rd_q, pd, pa} <= '0;
      {we_q, oe_q, ce_q, tog, alt, perr} <= 6'b111000;
      cnt <= 0;
      ecnt <= 0;
    end
    else
    begin
      we_q <= pins_i.we_n;
      oe_q <= pins_i.oe_n;
      ce_q <= pins_i.ce_n;
      if (cnt > 0) cnt <= cnt - 1;
      if (rd_ev)
      begin
        if (st == S_RD || (st == S_SU && !sel[blk])) rd_q <= mem[pins_i.addr];
        else
        begin
          rd_q <= stat();
          if (st != S_SU) tog <= ~tog;
          if (sel[blk] || bad[blk]) alt <= ~alt;
        end
      end
      case (st)
        S_PG: if (cnt == 0)
        begin
          if (|(pd & ~mem[pa])) st <= S_EE;
          else st <= S_RD;
          if (|(pd & ~mem[pa])) perr <= 1'b1;
          else mem[pa] <= pd;
        end
        S_WT: if (cnt == 0) st <= S_ER;
        S_SP: if (cnt == 0) st <= S_SU;
        S_ER: if (ecnt > 0) ecnt <= ecnt - 1;
        else
        begin
          sel <= '0;
          perr <= 1'b0;
          if (fail_i) bad <= sel;
          st <= fail_i ? S_EE : S_RD;
          if (!fail_i)
            for (int i = 0; i < 131072; i++) if (sel[i >> 14]) mem[i] <= 8'hff;
        end
        default: ;
      endcase
      if (wr_ev)
        case (st)
          S_RD: if (wd == ERASE_CODE)
          begin
            sel <= 8'h01 << blk;
            st <= S_WT;
            cnt <= WAIT_CYC;
            ecnt <= ERASE_CYC;
          end
          else if (!(wd inside {fes_pkg::CODE_SUSPEND, fes_pkg::CODE_RESUME,
                                fes_pkg::CODE_RESET}))
          begin
            pd <= wd;
            pa <= pins_i.addr;
            cnt <= PROG_CYC;
            st <= S_PG;
          end
          S_WT: if (wd == ERASE_CODE) sel[blk] <= 1'b1;
          else if (wd == fes_pkg::CODE_SUSPEND) st <= S_SU;
          S_ER: if (wd == fes_pkg::CODE_SUSPEND) st <= S_SP;
          S_SU: if (wd == fes_pkg::CODE_RESUME) st <= S_ER;
          S_EE: if (wd == fes_pkg::CODE_RESET) st <= S_RD;
          default: ;
        endcase
      if (wr_ev && st == S_WT && wd == ERASE_CODE) cnt <= WAIT_CYC;
      if (wr_ev && st == S_ER && wd == fes_pkg::CODE_SUSPEND) cnt <= SUSP_CYC;
      if (wr_ev && st == S_EE && wd == fes_pkg::CODE_RESET) bad <= '0;
    end
  end
endmodule  // fes_flash_model

/* File: verif/test_flash_erase_suspend_status.sv */
`timescale 1ns/1ps

// ---------------------------------------------------------------
// Bench
// ---------------------------------------------------------------
module test_flash_erase_suspend_status;
  localparam logic [7:0] EC = 8'h50;
  logic               clk_i = 1'b0;
  logic               arst_n_i = 1'b0;
  logic               req_valid_i = 1'b0;
  logic               fail = 1'b0;
  fes_pkg::fes_req_s  req_i = '0;
  fes_pkg::fes_pins_s pins;
  logic [7:0]         rdata, dq_m, rd, x1, x2, d;
  logic               rdy, vld, err, rfs, susp, est, win, late, rb, rerr, rref;
  logic [16:0]        a, ea;
  int                 num_errors = 0, cmp_count = 0, cyc = 0, seed = 32'h32a5;
  int                 ref_mem [int];
  wire  [7:0]         dq_w = pins.dq_oe ? pins.dq : dq_m;

  always #12.5 clk_i = ~clk_i;

  fes_host_ctrl dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .req_ready_o(rdy), .rsp_valid_o(vld), .rsp_data_o(rdata),
    .rsp_error_o(err), .rsp_refused_o(rfs), .suspended_o(susp), .erase_started_o(est),
    .add_window_o(win), .suspend_late_o(late), .pins_o(pins), .dq_i(dq_w),
    .ready_busy_out_i(rb));

  fes_flash_model #(.ERASE_CODE(EC)) flash (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .pins_i(pins), .fail_i(fail), .dq_o(dq_m), .ready_busy_out_o(rb));

  task automatic complete_run();
    if (num_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic int rm(input int k);
    return ref_mem.exists(k) ? ref_mem[k] : 32'hff;
  endfunction

  task automatic ers(input int b);
    int q[$];
    foreach (ref_mem[k]) if ((k >> 14) == b) q.push_back(k);
    foreach (q[i]) ref_mem.delete(q[i]);
  endtask

  task automatic op(input fes_pkg::fes_op_e o, input logic [16:0] ad,
                    input logic [7:0] dt = 8'h00);
    while (rdy !== 1'b1) @(posedge clk_i) #2;
    req_i = '{o, ad, dt};
    req_valid_i = 1'b1;
    @(posedge clk_i) #2;
    req_valid_i = 1'b0;
    while (vld !== 1'b1) @(posedge clk_i) #2;
    rd = rdata;
    rerr = err;
    rref = rfs;
    @(posedge clk_i) #2;
  endtask

  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      num_errors++;
      complete_run();
    end
  end

  initial
  begin
    repeat (6) @(posedge clk_i);
    #2 arst_n_i = 1'b1;
    @(posedge clk_i) #2;
    chk({3'h0, pins.ce_n, pins.oe_n, pins.we_n, pins.dq_oe, rdy}, 8'h1d);
    a = 17'($random(seed)) & 17'h03fff;
    d = 8'($random(seed)) & 8'h4f;
    op(fes_pkg::OP_WRITE, a, d);
    op(fes_pkg::OP_READ, a);
    x1 = rd;
    op(fes_pkg::OP_READ, a);
    chk(x1 & 8'h80, ~d & 8'h80);
    chk((x1 ^ rd) & 8'h40, 8'h40);
    op(fes_pkg::OP_POLL, a);
    chk({7'h0, rerr}, 8'h00);
    ref_mem[a] = d;
    op(fes_pkg::OP_READ, a);
    chk(rd, 8'(rm(a)));
    op(fes_pkg::OP_WRITE, a, d | 8'h80);
    op(fes_pkg::OP_POLL, a);
    chk({7'h0, rerr}, 8'h01);
    op(fes_pkg::OP_READ, a);
    chk({7'h0, rref}, 8'h01);
    op(fes_pkg::OP_RESET, a);
    op(fes_pkg::OP_READ, a);
    chk(rd, 8'(rm(a)));
    ea = {3'd1, 14'($random(seed))};
    op(fes_pkg::OP_WRITE, ea, EC);
    op(fes_pkg::OP_WRITE, {3'd2, 14'h0}, EC);
    chk({7'h0, win}, 8'h01);
    op(fes_pkg::OP_READ, ea);
    chk(rd & 8'h88, 8'h00);
    repeat (400) @(posedge clk_i) #2;
    op(fes_pkg::OP_READ, ea);
    x1 = rd;
    op(fes_pkg::OP_READ, a);
    x2 = rd;
    op(fes_pkg::OP_READ, ea);
    chk(rd & 8'h88, 8'h08);
    chk((x1 ^ x2) & 8'h40, 8'h40);
    chk((x2 ^ rd) & 8'h44, 8'h40);
    chk({7'h0, rb}, 8'h00);
    op(fes_pkg::OP_SUSPEND, ea);
    chk({6'h0, susp, late}, 8'h02);
    op(fes_pkg::OP_READ, a);
    chk(rd, 8'(rm(a)));
    op(fes_pkg::OP_READ, ea);
    x1 = rd;
    op(fes_pkg::OP_READ, ea);
    chk(x1 & 8'h80, 8'h80);
    chk((x1 ^ rd) & 8'h44, 8'h04);
    op(fes_pkg::OP_SUSPEND, ea);
    chk({7'h0, rref}, 8'h01);
    op(fes_pkg::OP_RESET, ea);
    chk({7'h0, susp}, 8'h01);
    repeat (2)
    begin
      op(fes_pkg::OP_RESUME, ea);
      op(fes_pkg::OP_SUSPEND, ea);
      chk({7'h0, susp}, 8'h01);
    end
    op(fes_pkg::OP_RESUME, ea);
    op(fes_pkg::OP_WRITE, a, d);
    chk({7'h0, rref}, 8'h01);
    op(fes_pkg::OP_POLL, ea);
    chk({7'h0, rerr}, 8'h00);
    ers(1);
    ers(2);
    op(fes_pkg::OP_READ, ea);
    chk(rd, 8'(rm(ea)));
    op(fes_pkg::OP_READ, a);
    chk(rd, 8'(rm(a)));
    ea = {3'd3, 14'($random(seed))};
    op(fes_pkg::OP_WRITE, ea, EC);
    op(fes_pkg::OP_SUSPEND, ea);
    chk({7'h0, susp}, 8'h01);
    op(fes_pkg::OP_RESUME, ea);
    op(fes_pkg::OP_READ, ea);
    chk(rd & 8'h08, 8'h08);
    op(fes_pkg::OP_POLL, ea);
    ers(3);
    fail = 1'b1;
    ea = {3'd5, 14'($random(seed))};
    op(fes_pkg::OP_WRITE, ea, EC);
    op(fes_pkg::OP_POLL, ea);
    chk({7'h0, rerr}, 8'h01);
    chk({7'h0, est}, 8'h01);
    fail = 1'b0;
    op(fes_pkg::OP_RESET, ea);
    op(fes_pkg::OP_READ, ea);
    chk(rd, 8'(rm(ea)));
    complete_run();
  end
endmodule  // test_flash_erase_suspend_status
